// [gpc_pin_model.sv]
// Pin-side model: outside drivers and floating pin levels
module gpc_pin_model
(
    input wire logic sys_clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEnable_n,
    input wire logic [7:0] extEn,
    input wire logic [7:0] extVal,
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] floatQ = 8'h55;
    always_ff @(posedge sys_clk)
        floatQ <= ~floatQ;
    // A released, undriven pin wanders so a stale value cannot pass
    always_comb
        for (int i = 0; i < 8; i++)
            pinIn[i] = !pinOutEnable_n[i] ? pinOut[i] :
                extEn[i] ? extVal[i] : floatQ[i];
endmodule

// [gpc_pkg.sv]
// Package for the eight-bit general-purpose port with analog select
package gpc_pkg;

    localparam int PORT_WIDTH = 8;

    // Register byte offsets on the bus (word aligned)
    localparam logic [3:0] OFS_PIN_VALUES = 4'h0;
    localparam logic [3:0] OFS_DIRECTION = 4'h4;
    localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h8;
    localparam logic [3:0] OFS_ANALOG_SELECT = 4'hC;

    // Reset values and the implemented-bit mask
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] ANALOG_IMPL_MASK = 8'hCF;
    localparam logic [7:0] ANALOG_RESET = 8'hCF;

    // Pin output sources after priority resolution
    typedef enum logic [4:0] {
        GPC_SRC_LATCH,
        GPC_SRC_PROG_DATA,
        GPC_SRC_PROG_CLOCK,
        GPC_SRC_I2C_SCL,
        GPC_SRC_I2C_SDA,
        GPC_SRC_SPI_SCK,
        GPC_SRC_SPI_SDI,
        GPC_SRC_SPI_SDO,
        GPC_SRC_CONV_1,
        GPC_SRC_CONV_2,
        GPC_SRC_REF_CLOCK,
        GPC_SRC_PULSE_WIDTH_OUT_1,
        GPC_SRC_PULSE_WIDTH_OUT_2,
        GPC_SRC_WAVE_A,
        GPC_SRC_WAVE_B,
        GPC_SRC_CMP1,
        GPC_SRC_CMP2,
        GPC_SRC_UART_TX,
        GPC_SRC_UART_RX
    } gpc_src_t;

    // One peripheral output request: enable and data
    typedef struct packed {
        logic en;
        logic dat;
    } gpc_periph_t;

    // All peripheral outputs that may reach the port
    typedef struct packed {
        gpc_periph_t progData;
        gpc_periph_t progClock;
        gpc_periph_t i2cScl;
        gpc_periph_t i2cSda;
        gpc_periph_t spiSck;
        gpc_periph_t spiSdi;
        gpc_periph_t spiSdo;
        gpc_periph_t conv1;
        gpc_periph_t conv2;
        gpc_periph_t refClock;
        gpc_periph_t pulse_width_out_1;
        gpc_periph_t pulse_width_out_2;
        gpc_periph_t waveA;
        gpc_periph_t waveB;
        gpc_periph_t cmp1;
        gpc_periph_t cmp2;
        gpc_periph_t uartTx;
        gpc_periph_t uartRx;
    } gpc_periphs_t;

    // Alternate pin selections for relocatable outputs
    typedef struct packed {
        logic spiSdoOnPin7;
        logic pwm2OnPin6;
        logic refClockOnPin3;
    } gpc_altsel_t;

endpackage

// [gpc_port.sv]
// Eight-bit port: registers, Avalon-MM slave and output priority muxing
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
module gpc_port
    import gpc_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic powerOnReset_n,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic [1:0] avsResponse,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOutEnable_n,
    input wire gpc_periphs_t periphs,
    input wire gpc_altsel_t altSel,
    output logic [WIDTH-1:0] digitalIn,
    output logic [WIDTH-1:0] analogSelect
);

    // Register state
    logic [WIDTH-1:0] directionQ;
    logic [WIDTH-1:0] latchQ;
    logic [WIDTH-1:0] analogQ;
    logic [WIDTH-1:0] pinValues;
    logic [WIDTH-1:0] drvData;
    logic [WIDTH-1:0] drvOverride;
    gpc_src_t pinSrc [WIDTH];
    // Bus slave state
    logic ackQ;
    logic [31:0] readDataQ;
    logic [1:0] responseQ;
    logic accept;
    logic hit;
    logic [WIDTH-1:0] readMux;
    logic wrDirection;
    logic wrAnalog;
    logic wrPinValues;
    logic wrLatch;

    // Pick the first enabled request in priority order
    // Later tests win, so the highest priority is tested last
    function automatic gpc_src_t pick(
        input logic e0, input gpc_src_t s0,
        input logic e1, input gpc_src_t s1,
        input logic e2, input gpc_src_t s2,
        input logic e3, input gpc_src_t s3,
        input logic e4, input gpc_src_t s4
    );
        gpc_src_t r;
        r = GPC_SRC_LATCH;
        if (e4)
            r = s4;
        if (e3)
            r = s3;
        if (e2)
            r = s2;
        if (e1)
            r = s1;
        if (e0)
            r = s0;
        return r;
    endfunction

    // Data value of a resolved source
    function automatic logic srcData(
        input gpc_src_t s,
        input gpc_periphs_t p,
        input logic lat
    );
        logic d;
        d = lat;
        unique case (s)
            GPC_SRC_LATCH: d = lat;
            GPC_SRC_PROG_DATA: d = p.progData.dat;
            GPC_SRC_PROG_CLOCK: d = p.progClock.dat;
            GPC_SRC_I2C_SCL: d = p.i2cScl.dat;
            GPC_SRC_I2C_SDA: d = p.i2cSda.dat;
            GPC_SRC_SPI_SCK: d = p.spiSck.dat;
            GPC_SRC_SPI_SDI: d = p.spiSdi.dat;
            GPC_SRC_SPI_SDO: d = p.spiSdo.dat;
            GPC_SRC_CONV_1: d = p.conv1.dat;
            GPC_SRC_CONV_2: d = p.conv2.dat;
            GPC_SRC_REF_CLOCK: d = p.refClock.dat;
            GPC_SRC_PULSE_WIDTH_OUT_1: d = p.pulse_width_out_1.dat;
            GPC_SRC_PULSE_WIDTH_OUT_2: d = p.pulse_width_out_2.dat;
            GPC_SRC_WAVE_A: d = p.waveA.dat;
            GPC_SRC_WAVE_B: d = p.waveB.dat;
            GPC_SRC_CMP1: d = p.cmp1.dat;
            GPC_SRC_CMP2: d = p.cmp2.dat;
            GPC_SRC_UART_TX: d = p.uartTx.dat;
            GPC_SRC_UART_RX: d = p.uartRx.dat;
            // Codes outside the list fall back to the latch
            default: d = lat;
        endcase
        return d;
    endfunction

    // Output priority per pin, highest first
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
            pinSrc[i] = GPC_SRC_LATCH;
        // Pin 0: programming data, two-wire clock, serial clock
        pinSrc[0] = pick(
            periphs.progData.en,
            GPC_SRC_PROG_DATA,
            periphs.i2cScl.en,
            GPC_SRC_I2C_SCL,
            periphs.spiSck.en,
            GPC_SRC_SPI_SCK,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 1: programming clock, two-wire data, serial data in
        pinSrc[1] = pick(
            periphs.progClock.en,
            GPC_SRC_PROG_CLOCK,
            periphs.i2cSda.en,
            GPC_SRC_I2C_SDA,
            periphs.spiSdi.en,
            GPC_SRC_SPI_SDI,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 2: converter output 1, serial data out on its default pin
        pinSrc[2] = pick(
            periphs.conv1.en,
            GPC_SRC_CONV_1,
            periphs.spiSdo.en && !altSel.spiSdoOnPin7,
            GPC_SRC_SPI_SDO,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 3: converter output 2, reference clock, pulse width 2
        pinSrc[3] = pick(
            periphs.conv2.en,
            GPC_SRC_CONV_2,
            periphs.refClock.en && altSel.refClockOnPin3,
            GPC_SRC_REF_CLOCK,
            periphs.pulse_width_out_2.en && !altSel.pwm2OnPin6,
            GPC_SRC_PULSE_WIDTH_OUT_2,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 4: waveform B, comparator 1, comparator 2, serial transmit
        pinSrc[4] = pick(
            periphs.waveB.en,
            GPC_SRC_WAVE_B,
            periphs.cmp1.en,
            GPC_SRC_CMP1,
            periphs.cmp2.en,
            GPC_SRC_CMP2,
            periphs.uartTx.en,
            GPC_SRC_UART_TX,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 5: waveform A, pulse width 1, serial receive
        pinSrc[5] = pick(
            periphs.waveA.en,
            GPC_SRC_WAVE_A,
            periphs.pulse_width_out_1.en,
            GPC_SRC_PULSE_WIDTH_OUT_1,
            periphs.uartRx.en,
            GPC_SRC_UART_RX,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 6: pulse width 2 on its alternate pin
        pinSrc[6] = pick(
            periphs.pulse_width_out_2.en && altSel.pwm2OnPin6,
            GPC_SRC_PULSE_WIDTH_OUT_2,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
        // Pin 7: serial data out on its alternate pin
        pinSrc[7] = pick(
            periphs.spiSdo.en && altSel.spiSdoOnPin7,
            GPC_SRC_SPI_SDO,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH,
            1'b0,
            GPC_SRC_LATCH);
    end

    // Drivers: a peripheral drives its pin, else the direction bit rules
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            drvOverride[i] = (pinSrc[i] != GPC_SRC_LATCH);
            drvData[i] = srcData(pinSrc[i], periphs, latchQ[i]);
        end
    end

    // Pin 0 with nothing enabled falls back to the latch
    assign pinOut = drvData;
    // Analog select plays no part in the driver enable
    assign pinOutEnable_n = directionQ & ~drvOverride;

    // Digital input buffer disabled on analog pins
    assign pinValues = pinIn & ~analogQ;
    // Peripheral inputs see the same buffers whatever the direction
    assign digitalIn = pinValues;
    assign analogSelect = analogQ;

    // Avalon-MM slave: one wait cycle, answer on the following edge
    // ackQ drops after the accepting edge, so a request held over that
    // edge counts as a new one and waits a cycle again
    assign hit = (avsRead || avsWrite) && !ackQ;
    assign accept = (avsRead || avsWrite) && ackQ;
    assign avsWaitRequest = (avsRead || avsWrite) && !ackQ;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ackQ <= 1'b0;
        else
            ackQ <= hit;
    end

    // Merge byte lane 0 of the write onto a base value
    function automatic logic [7:0] merge(
        input logic [7:0] base,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [7:0] r;
        r = base;
        if (be[0])
            r = wd[7:0];
        return r;
    endfunction

    // Write strobes, one per register, only on the accepting edge
    assign wrDirection = accept && avsWrite && avsAddress == OFS_DIRECTION;
    assign wrAnalog = accept && avsWrite && avsAddress == OFS_ANALOG_SELECT;
    assign wrPinValues = accept && avsWrite && avsAddress == OFS_PIN_VALUES;
    assign wrLatch = accept && avsWrite && avsAddress == OFS_OUTPUT_LATCH;

    // Direction bits: 1 releases the pin driver
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            directionQ <= DIRECTION_RESET;
        else if (wrDirection)
            directionQ <= merge(directionQ, avsWriteData, avsByteEnable);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            analogQ <= ANALOG_RESET;
        // Unimplemented bits stay zero on every write
        else if (wrAnalog)
            analogQ <= merge(analogQ, avsWriteData, avsByteEnable)
                & ANALOG_IMPL_MASK;
    end

    // Latch holds over the ordinary reset, cleared only at power-on
    // A pin-value write starts from the sampled pins, so analog pins
    // that read 0 lose their latch bit when the byte is not written
    always_ff @(posedge sys_clk or negedge powerOnReset_n)
    begin
        if (!powerOnReset_n)
            latchQ <= '0;
        else if (wrPinValues)
            latchQ <= merge(pinValues, avsWriteData,
                avsByteEnable);
        else if (wrLatch)
            latchQ <= merge(latchQ, avsWriteData, avsByteEnable);
    end

    // True for the four register offsets
    function automatic logic mapped(input logic [3:0] a);
        logic m;
        m = 1'b0;
        unique case (a)
            OFS_PIN_VALUES: m = 1'b1;
            OFS_DIRECTION: m = 1'b1;
            OFS_OUTPUT_LATCH: m = 1'b1;
            OFS_ANALOG_SELECT: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    // Read selection, unmapped offsets read zero
    always_comb
    begin
        readMux = '0;
        unique case (avsAddress)
            OFS_PIN_VALUES: readMux = pinValues;
            OFS_DIRECTION: readMux = directionQ;
            OFS_OUTPUT_LATCH: readMux = latchQ;
            OFS_ANALOG_SELECT: readMux = analogQ & ANALOG_IMPL_MASK;
            default: readMux = '0;
        endcase
    end

    // Read data is captured in the wait cycle and stands at the answer
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            readDataQ <= 32'h0000_0000;
        else if (hit && avsRead)
            readDataQ <= {{(32-WIDTH){1'b0}}, readMux};
    end

    // Unmapped offsets answer with a decode error
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            responseQ <= 2'h0;
        else if (hit)
            responseQ <= mapped(avsAddress) ? 2'h0 : 2'h3;
    end

    assign avsReadData = readDataQ;
    assign avsResponse = responseQ;

endmodule

// [gpc_port_sva.sv]
// Checker: bus timing, reset values, input buffers and pin priorities
module gpc_port_sva
    import gpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic [31:0] avsReadData,
    input wire logic [7:0] pinIn,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEnable_n,
    input wire gpc_periphs_t periphs,
    input wire logic [7:0] digitalIn,
    input wire logic [7:0] analogSelect
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rdWait;
        avsRead && avsWaitRequest;
    endsequence
    sequence s_rdDone;
        !avsWaitRequest && avsReadData[31:8] == 24'h0;
    endsequence
    property p_readOneWait;
        s_rdWait |=> s_rdDone;
    endproperty
    a_readOneWait: assert property (p_readOneWait)
        else $error("read answer not after one wait cycle");
    property p_writeOneWait;
        avsWrite && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    a_writeOneWait: assert property (p_writeOneWait)
        else $error("write answer not after one wait cycle");
    property p_resetDir;
        $rose(reset_n) && periphs == '0 |-> pinOutEnable_n == 8'hFF;
    endproperty
    a_resetDir: assert property (p_resetDir)
        else $error("pins driven after reset");
    property p_resetAnalog;
        $rose(reset_n) |-> analogSelect == 8'hCF;
    endproperty
    a_resetAnalog: assert property (p_resetAnalog)
        else $error("analog select wrong after reset");
    property p_unimpl;
        analogSelect[5:4] == 2'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented analog bits set");
    property p_inBuffer;
        digitalIn == (pinIn & ~analogSelect);
    endproperty
    a_inBuffer: assert property (p_inBuffer)
        else $error("digital input not masked by analog select");
    property p_pin0Top;
        periphs.progData.en |->
            !pinOutEnable_n[0] && pinOut[0] == periphs.progData.dat;
    endproperty
    a_pin0Top: assert property (p_pin0Top)
        else $error("pin 0 top source not driving");
    property p_pin4Top;
        periphs.waveB.en |->
            !pinOutEnable_n[4] && pinOut[4] == periphs.waveB.dat;
    endproperty
    a_pin4Top: assert property (p_pin4Top)
        else $error("pin 4 top source not driving");
    property p_pin5Next;
        !periphs.waveA.en && periphs.pulse_width_out_1.en |-> pinOut[5] == periphs.pulse_width_out_1.dat;
    endproperty
    a_pin5Next: assert property (p_pin5Next)
        else $error("pin 5 second source not driving");
endmodule

bind gpc_port gpc_port_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWaitRequest(avsWaitRequest), .avsReadData(avsReadData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOutEnable_n(pinOutEnable_n),
    .periphs(periphs), .digitalIn(digitalIn), .analogSelect(analogSelect));

// [test_eight_bit_gpio_port_with_analog_select.sv]
// Testbench for the eight-bit port with analog select
module test_eight_bit_gpio_port_with_analog_select import gpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, reset_n = 1'h0, powerOnReset_n = 1'h0;
    logic [3:0] avsAddress = 4'h0;
    logic [3:0] avsByteEnable = 4'h1;
    logic avsRead = 1'h0, avsWrite = 1'h0, avsWaitRequest;
    logic [31:0] avsWriteData = 32'h0, avsReadData, rdq;
    logic [1:0] avsResponse, rsp;
    logic [7:0] pinIn, pinOut, pinOutEnable_n, digitalIn, analogSelect;
    logic [7:0] extEn = 8'h00, extVal = 8'h00;
    gpc_periphs_t periphs = '0;
    gpc_altsel_t altSel = '0;
    int fail_count = 0, checks_done = 0;
    int pr[17][4] = '{'{0,2,0,0}, '{2,4,0,0}, '{1,3,1,0}, '{3,5,1,0},
        '{7,6,2,0}, '{6,-1,2,0}, '{8,11,3,0}, '{8,9,3,7}, '{9,-1,3,7},
        '{13,14,4,0}, '{14,15,4,0}, '{15,16,4,0}, '{12,10,5,0},
        '{10,17,5,0}, '{17,-1,5,0}, '{11,-1,6,7}, '{6,-1,7,7}};
    gpc_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .powerOnReset_n(powerOnReset_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
        .pinIn(pinIn), .pinOut(pinOut), .pinOutEnable_n(pinOutEnable_n),
        .periphs(periphs), .altSel(altSel), .digitalIn(digitalIn),
        .analogSelect(analogSelect));
    gpc_pin_model i_pins (.sys_clk(sys_clk), .pinOut(pinOut),
        .pinOutEnable_n(pinOutEnable_n), .extEn(extEn), .extVal(extVal),
        .pinIn(pinIn));
    initial
        forever #25 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic xfer(input logic wr, input logic [3:0] a,
        input logic [7:0] d);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= {24'h0, d};
        do @(posedge sys_clk); while (avsWaitRequest !== 1'h0);
        rdq = avsReadData;
        rsp = avsResponse;
        avsRead <= 1'h0;
        avsWrite <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        xfer(1'h0, a, 8'h00);
        chk($sformatf("read %h", a), {24'h0, exp}, rdq);
    endtask
    function automatic gpc_periphs_t pe(int k, logic d);
        pe = '0;
        pe[35 - 2 * k] = 1'h1;
        pe[34 - 2 * k] = d;
    endfunction
    task automatic t_reset;
        rdchk(OFS_DIRECTION, 8'hFF);
        chk("response ok", 2'h0, rsp);
        rdchk(OFS_ANALOG_SELECT, 8'hCF);
        rdchk(OFS_OUTPUT_LATCH, 8'h00);
        xfer(1'h1, OFS_ANALOG_SELECT, 8'hFF);
        rdchk(OFS_ANALOG_SELECT, 8'hCF);
        rdchk(4'h2, 8'h00);
        chk("response", 2'h3, rsp);
        $display("test reset values done");
    endtask
    task automatic t_pins;
        xfer(1'h1, OFS_ANALOG_SELECT, 8'h00);
        xfer(1'h1, OFS_DIRECTION, 8'h00);
        xfer(1'h1, OFS_OUTPUT_LATCH, 8'hA5);
        chk("pinOut", 8'hA5, pinOut);
        chk("enable", 8'h00, pinOutEnable_n);
        chk("digitalIn", 8'hA5, digitalIn);
        rdchk(OFS_PIN_VALUES, 8'hA5);
        xfer(1'h1, OFS_ANALOG_SELECT, 8'hCF);
        rdchk(OFS_PIN_VALUES, 8'h20);
        chk("pinOut", 8'hA5, pinOut);
        chk("enable", 8'h00, pinOutEnable_n);
        xfer(1'h1, OFS_PIN_VALUES, 8'h3C);
        rdchk(OFS_OUTPUT_LATCH, 8'h3C);
        avsByteEnable <= 4'h0;
        xfer(1'h1, OFS_PIN_VALUES, 8'hFF);
        avsByteEnable <= 4'h1;
        rdchk(OFS_OUTPUT_LATCH, 8'h30);
        extEn <= 8'hFF;
        extVal <= 8'h96;
        xfer(1'h1, OFS_DIRECTION, 8'hFF);
        chk("enable", 8'hFF, pinOutEnable_n);
        xfer(1'h1, OFS_ANALOG_SELECT, 8'h00);
        rdchk(OFS_PIN_VALUES, 8'h96);
        rdchk(OFS_OUTPUT_LATCH, 8'h30);
        $display("test pin paths done");
    endtask
    task automatic t_prio;
        xfer(1'h1, OFS_OUTPUT_LATCH, 8'h00);
        foreach (pr[i])
        begin
            periphs <= pe(pr[i][0], 1'h1) |
                (pr[i][1] < 0 ? '0 : pe(pr[i][1], 1'h0));
            altSel <= gpc_altsel_t'(pr[i][3][2:0]);
            @(negedge sys_clk);
            chk("prio data", 1'h1, pinOut[pr[i][2]]);
            chk("prio en", 1'h0, pinOutEnable_n[pr[i][2]]);
            @(posedge sys_clk);
        end
        periphs <= '0;
        @(posedge sys_clk);
        $display("test priorities done");
    endtask
    task automatic t_rst2;
        xfer(1'h1, OFS_OUTPUT_LATCH, 8'h5A);
        xfer(1'h1, OFS_DIRECTION, 8'h0F);
        reset_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        rdchk(OFS_OUTPUT_LATCH, 8'h5A);
        rdchk(OFS_DIRECTION, 8'hFF);
        rdchk(OFS_ANALOG_SELECT, 8'hCF);
        $display("test warm reset done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'h1;
        powerOnReset_n <= 1'h1;
        @(posedge sys_clk);
        t_reset;
        t_pins;
        t_prio;
        t_rst2;
        give_verdict;
    end
    initial
    begin
        #100000;
        fail_count++;
        give_verdict;
    end
endmodule
